// ==== lsal_alert_top.v ====
// Purpose: limit status flags, alert masks and active-low alert output
// Assumes: channel results arrive synchronous to clk; host register port is one-cycle strobes
// Notes:   measurement engines and thermal timer live outside; they supply condition levels
`timescale 1ns/1ps
`default_nettype none
`include "lsal_defs.vh"

// Functional notes
// - primary bit 7 set while any secondary flag is set.
// - primary bits 6..0: remote2, local, remote1, 5V, supply, core, 2.5V breaches.
// - secondary bits 7 and 6 flag diode two and diode one faults.
// - secondary bit 5 flags fan four slow, or thermal limit when thermal pin.
// - secondary bits 4..2 flag fans three, two, one below minimum speed.
// - secondary bit 1 flags any overtemperature limit exceeded.
// - secondary bit 0 flags 12V breach, or VID code change when selected.
// - flags are sticky until cause gone and register read.
// - alert stays low while unmasked condition persists and until status read.
// - masks block only the alert; flags still set.
// - primary mask mirrors primary flags; bit 7 masks all secondary sources.
// - secondary mask bit 5 masks fan four or thermal timer event.
// - secondary mask bits 7,6,4..1 mask diodes, fans and overtemperature.
// - secondary mask bit 0 masks 12V or VID change, per selection.
// - alert disabled after reset; enabled by config3 bit 0.
// - high breach is strictly greater; low breach is less or equal.
// - read clears only flags whose condition already cleared.
module lsal_alert_top (
    input  wire       clk,
    input  wire       resetn,
    input  wire [7:0] reg_addr,
    input  wire       reg_wr,
    input  wire       reg_rd,
    input  wire [7:0] reg_wdata,
    output reg  [7:0] reg_rdata_r,
    input  wire [7:0] remote_two_temp,
    input  wire [7:0] remote_two_low,
    input  wire [7:0] remote_two_high,
    input  wire [7:0] local_temp,
    input  wire [7:0] local_low,
    input  wire [7:0] local_high,
    input  wire [7:0] remote_one_temp,
    input  wire [7:0] remote_one_low,
    input  wire [7:0] remote_one_high,
    input  wire [7:0] five_volt,
    input  wire [7:0] five_volt_low,
    input  wire [7:0] five_volt_high,
    input  wire [7:0] supply_volt,
    input  wire [7:0] supply_low,
    input  wire [7:0] supply_high,
    input  wire [7:0] core_volt,
    input  wire [7:0] core_low,
    input  wire [7:0] core_high,
    input  wire [7:0] two_point_five,
    input  wire [7:0] two_point_five_low,
    input  wire [7:0] two_point_five_high,
    input  wire [7:0] twelve_volt,
    input  wire [7:0] twelve_volt_low,
    input  wire [7:0] twelve_volt_high,
    input  wire       diode_two_fault,
    input  wire       diode_one_fault,
    input  wire       fan_four_slow,
    input  wire       thermal_limit_exceeded,
    input  wire       thermal_pin_select,
    input  wire       fan_three_slow,
    input  wire       fan_two_slow,
    input  wire       fan_one_slow,
    input  wire       overtemperature,
    input  wire       code_change_select,
    input  wire [5:0] voltage_code,
    output wire       alert_n
);
    reg  [7:0] primary_alert_mask_r;
    reg  [7:0] secondary_alert_mask_r;
    reg  [7:0] config3_r;
    reg  [5:0] code_prev_r;
    reg        code_valid_r;
    wire [7:0] primary_limit_flags;
    wire [7:0] secondary_fault_flags;
    wire [7:0] primary_cond;
    wire [7:0] secondary_cond;
    wire       rd_primary;
    wire       rd_secondary;
    wire       code_changed;
    wire       twelve_oor;
    wire       primary_pending;
    wire       secondary_pending;
    wire       alert_enable;

    // per-channel limit comparators, bit order is the flag order
    lsal_limit_cmp u_cmp6 (.value(remote_two_temp), .low_limit(remote_two_low),
        .high_limit(remote_two_high), .out_of_limit(primary_cond[6]));
    lsal_limit_cmp u_cmp5 (.value(local_temp), .low_limit(local_low),
        .high_limit(local_high), .out_of_limit(primary_cond[5]));
    lsal_limit_cmp u_cmp4 (.value(remote_one_temp), .low_limit(remote_one_low),
        .high_limit(remote_one_high), .out_of_limit(primary_cond[4]));
    lsal_limit_cmp u_cmp3 (.value(five_volt), .low_limit(five_volt_low),
        .high_limit(five_volt_high), .out_of_limit(primary_cond[3]));
    lsal_limit_cmp u_cmp2 (.value(supply_volt), .low_limit(supply_low),
        .high_limit(supply_high), .out_of_limit(primary_cond[2]));
    lsal_limit_cmp u_cmp1 (.value(core_volt), .low_limit(core_low),
        .high_limit(core_high), .out_of_limit(primary_cond[1]));
    lsal_limit_cmp u_cmp0 (.value(two_point_five), .low_limit(two_point_five_low),
        .high_limit(two_point_five_high), .out_of_limit(primary_cond[0]));
    lsal_limit_cmp u_cmp12 (.value(twelve_volt), .low_limit(twelve_volt_low),
        .high_limit(twelve_volt_high), .out_of_limit(twelve_oor));

    // summary follows the secondary flags, so it is a live condition too
    assign primary_cond[`LSAL_SUMMARY_BIT] = |secondary_fault_flags;

    // code change is a one-cycle event; the sticky flag holds it
    assign code_changed = code_valid_r && (voltage_code != code_prev_r);

    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            code_prev_r  <= 6'h00;
            code_valid_r <= 1'b0;
        end else begin
            code_prev_r  <= voltage_code;
            code_valid_r <= 1'b1;
        end
    end

    assign secondary_cond[7] = diode_two_fault;
    assign secondary_cond[6] = diode_one_fault;
    assign secondary_cond[5] = thermal_pin_select ? thermal_limit_exceeded : fan_four_slow;
    assign secondary_cond[4] = fan_three_slow;
    assign secondary_cond[3] = fan_two_slow;
    assign secondary_cond[2] = fan_one_slow;
    assign secondary_cond[1] = overtemperature;
    assign secondary_cond[0] = code_change_select ? code_changed : twelve_oor;

    assign rd_primary   = reg_rd && (reg_addr == `LSAL_ADDR_PRIMARY_FLAGS);
    assign rd_secondary = reg_rd && (reg_addr == `LSAL_ADDR_SECONDARY_FLAGS);

    // flags set regardless of masks
    lsal_sticky_reg u_primary (
        .clk       (clk),
        .resetn    (resetn),
        .cond      (primary_cond),
        .rd_strobe (rd_primary),
        .flags_r   (primary_limit_flags)
    );
    lsal_sticky_reg u_secondary (
        .clk       (clk),
        .resetn    (resetn),
        .cond      (secondary_cond),
        .rd_strobe (rd_secondary),
        .flags_r   (secondary_fault_flags)
    );

    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            primary_alert_mask_r   <= `LSAL_MASK_RESET;
            secondary_alert_mask_r <= `LSAL_MASK_RESET;
            config3_r              <= `LSAL_CONFIG3_RESET;
        end else if (reg_wr) begin
            case (reg_addr)
                `LSAL_ADDR_PRIMARY_MASK:   primary_alert_mask_r   <= reg_wdata;
                `LSAL_ADDR_SECONDARY_MASK: secondary_alert_mask_r <= reg_wdata;
                `LSAL_ADDR_CONFIG3:        config3_r              <= reg_wdata;
                default: ;
            endcase
        end
    end

    // read data registered; the clearing read returns pre-clear flags
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            reg_rdata_r <= 8'h00;
        end else if (reg_rd) begin
            case (reg_addr)
                `LSAL_ADDR_PRIMARY_FLAGS:   reg_rdata_r <= primary_limit_flags;
                `LSAL_ADDR_SECONDARY_FLAGS: reg_rdata_r <= secondary_fault_flags;
                `LSAL_ADDR_PRIMARY_MASK:    reg_rdata_r <= primary_alert_mask_r;
                `LSAL_ADDR_SECONDARY_MASK:  reg_rdata_r <= secondary_alert_mask_r;
                `LSAL_ADDR_CONFIG3:         reg_rdata_r <= config3_r;
                default:                    reg_rdata_r <= 8'h00;
            endcase
        end
    end

    // per-bit secondary masks, then the summary mask over the whole group
    assign secondary_pending = |(secondary_fault_flags & ~secondary_alert_mask_r);
    assign primary_pending   = |(primary_limit_flags[6:0] & ~primary_alert_mask_r[6:0]) ||
                               (secondary_pending && !primary_alert_mask_r[`LSAL_SUMMARY_BIT]);
    assign alert_enable      = config3_r[`LSAL_CFG3_ALERT_EN_BIT];
    // flags hold while the cause lasts, so the alert follows them
    assign alert_n = ~(alert_enable && primary_pending);
endmodule // lsal_alert_top
`default_nettype wire

// ==== lsal_alert_top_properties.sv ====
// Purpose: port-level properties of the limit status and alert logic
// Assumes: bound into lsal_alert_top, one clock domain
// Notes:   read data shows one cycle after the read strobe
`timescale 1ns/1ps
`default_nettype none
module lsal_alert_props (
    input wire       clk,
    input wire       resetn,
    input wire [7:0] reg_addr,
    input wire       reg_wr,
    input wire       reg_rd,
    input wire [7:0] reg_wdata,
    input wire [7:0] reg_rdata_r,
    input wire [7:0] local_temp,
    input wire [7:0] local_low,
    input wire [7:0] local_high,
    input wire       diode_two_fault,
    input wire       alert_n
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    wire rd41 = reg_rd && reg_addr == 8'h41;
    wire rd42 = reg_rd && reg_addr == 8'h42;
    a_high_strict: assert property (local_temp > local_high ##1 rd41 |=> reg_rdata_r[5])
        else $error("high breach not flagged");
    a_low_inclusive: assert property (local_temp <= local_low ##1 rd41 |=> reg_rdata_r[5])
        else $error("low breach not flagged");
    a_diode_flag: assert property (diode_two_fault ##1 rd42 |=> reg_rdata_r[7])
        else $error("diode fault not flagged");
    a_summary_flag: assert property (rd42 ##1 reg_rdata_r != 8'h00 ##1 rd41 |=> reg_rdata_r[7])
        else $error("summary flag missing");
    a_persist_read: assert property (rd42 && diode_two_fault ##2 rd42 |=> reg_rdata_r[7])
        else $error("live flag cleared by read");
    a_mask_rdback: assert property (reg_wr && reg_addr == 8'h74 ##2 reg_rd && reg_addr == 8'h74
        |=> reg_rdata_r == $past(reg_wdata, 3)) else $error("mask readback wrong");
    a_alert_reset: assert property ($rose(resetn) |-> alert_n)
        else $error("alert active after reset");
    a_rdata_hold: assert property (!reg_rd |=> $stable(reg_rdata_r))
        else $error("read data moved without read");
    cover property (rd42 && diode_two_fault);
    cover property ($fell(alert_n));
    cover property (reg_wr && reg_addr == 8'h78);
endmodule // lsal_alert_props
bind lsal_alert_top lsal_alert_props u_props (.*);
`default_nettype wire

// ==== lsal_defs.vh ====
// Purpose: constants for the limit status and alert logic
// Assumes: 8-bit register port, one 100 MHz clock
// Notes:   offsets are the device register addresses
`ifndef LSAL_DEFS_VH
`define LSAL_DEFS_VH
`define LSAL_ADDR_PRIMARY_FLAGS   8'h41
`define LSAL_ADDR_SECONDARY_FLAGS 8'h42
`define LSAL_ADDR_PRIMARY_MASK    8'h74
`define LSAL_ADDR_SECONDARY_MASK  8'h75
`define LSAL_ADDR_CONFIG3         8'h78
`define LSAL_MASK_RESET           8'h00
`define LSAL_CONFIG3_RESET        8'h00
`define LSAL_CFG3_ALERT_EN_BIT    0
`define LSAL_SUMMARY_BIT          7
`define LSAL_SEC_FAN_FOUR_MASK_THERMAL_PIN_BIT   5
`define LSAL_SEC_TWELVE_VC_BIT    0
`endif

// ==== lsal_host_model.sv ====
// Purpose: host side of the register port
// Assumes: one strobe cycle per access
// Notes:   idle address and data are scrambled so stale values never help
`timescale 1ns/1ps
`default_nettype none
module lsal_host_model (
    input  wire        clk,
    output logic [7:0] reg_addr,
    output logic       reg_wr,
    output logic       reg_rd,
    output logic [7:0] reg_wdata,
    output logic       rd_valid
);
    initial begin
        {reg_addr, reg_wr, reg_rd, reg_wdata} = 18'h0;
    end
    always @(posedge clk) rd_valid <= reg_rd;
    task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(posedge clk) #1;
        {reg_wr, reg_rd, reg_addr, reg_wdata} = {w, !w, a, d};
        @(posedge clk) #1;
        {reg_wr, reg_rd, reg_addr, reg_wdata} = {2'b00, 16'($urandom)};
    endtask
endmodule // lsal_host_model
`default_nettype wire

// ==== lsal_limit_cmp.v ====
// Purpose: high and low limit comparison for one 8-bit channel
// Assumes: unsigned values
// Notes:   high is strict, low includes equality
`timescale 1ns/1ps
`default_nettype none
module lsal_limit_cmp (
    input  wire [7:0] value,
    input  wire [7:0] low_limit,
    input  wire [7:0] high_limit,
    output wire       out_of_limit
);
    assign out_of_limit = (value > high_limit) || (value <= low_limit);
endmodule // lsal_limit_cmp
`default_nettype wire

// ==== lsal_sticky_reg.v ====
// Purpose: eight sticky status flags, cleared by a read once the cause is gone
// Assumes: rd_strobe is a one-cycle pulse
// Notes:   a live condition always wins over the read clear
`timescale 1ns/1ps
`default_nettype none
module lsal_sticky_reg (
    input  wire       clk,
    input  wire       resetn,
    input  wire [7:0] cond,
    input  wire       rd_strobe,
    output reg  [7:0] flags_r
);
    wire [7:0] flags_nxt;
    // a read only drops flags whose cause has already cleared
    assign flags_nxt = cond | (rd_strobe ? 8'h00 : flags_r);
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            flags_r <= 8'h00;
        end else begin
            flags_r <= flags_nxt;
        end
    end
endmodule // lsal_sticky_reg
`default_nettype wire

// ==== tb.sv ====
// Purpose: self-checking bench for lsal_alert_top
// Assumes: host model drives the register port
// Notes:   read results are queued by the driver, compared by a watcher
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic       clk = 0;
    logic       resetn = 0;
    logic [7:0] v [8];
    logic [7:0] lo [8];
    logic [7:0] hi [8];
    logic [7:0] c = 0;
    logic       tl = 0, tps = 0, ccs = 0;
    logic [5:0] code = 0;
    logic [7:0] q [$];
    logic [7:0] e, m;
    logic [7:0] ra [5] = '{8'h41, 8'h42, 8'h74, 8'h75, 8'h10};
    wire  [7:0] addr, wdata, rdata;
    wire        host_wr, host_rd, rv, alert_n;
    int         n_mismatch = 0, check_count = 0;
    always #5 clk = ~clk;
    lsal_host_model u_host (.clk(clk), .reg_addr(addr), .reg_wr(host_wr), .reg_rd(host_rd), .reg_wdata(wdata),
        .rd_valid(rv));
    lsal_alert_top u_lsal_alert_top (.clk(clk), .resetn(resetn), .reg_addr(addr), .reg_wr(host_wr), .reg_rd(host_rd),
        .reg_wdata(wdata), .reg_rdata_r(rdata), .alert_n(alert_n), .voltage_code(code),
        .remote_two_temp(v[0]), .remote_two_low(lo[0]), .remote_two_high(hi[0]),
        .local_temp(v[1]), .local_low(lo[1]), .local_high(hi[1]),
        .remote_one_temp(v[2]), .remote_one_low(lo[2]), .remote_one_high(hi[2]),
        .five_volt(v[3]), .five_volt_low(lo[3]), .five_volt_high(hi[3]),
        .supply_volt(v[4]), .supply_low(lo[4]), .supply_high(hi[4]),
        .core_volt(v[5]), .core_low(lo[5]), .core_high(hi[5]),
        .two_point_five(v[6]), .two_point_five_low(lo[6]), .two_point_five_high(hi[6]),
        .twelve_volt(v[7]), .twelve_volt_low(lo[7]), .twelve_volt_high(hi[7]),
        .diode_two_fault(c[7]), .diode_one_fault(c[6]), .fan_four_slow(c[5]), .fan_three_slow(c[4]),
        .fan_two_slow(c[3]), .fan_one_slow(c[2]), .overtemperature(c[1]), .thermal_limit_exceeded(tl),
        .thermal_pin_select(tps), .code_change_select(ccs));
    task automatic results();
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    // all causes back inside limits, values random within the window
    task automatic calm();
        for (int i = 0; i < 8; i++) begin
            lo[i] = 8'h10;
            hi[i] = 8'hf0;
            v[i] = 8'h11 + 8'($urandom % 224);
        end
        c = 0;
        tl = 0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] x);
        q.push_back(x);
        u_host.xfer(1'b0, a, 8'h00);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        u_host.xfer(1'b1, a, d);
    endtask
    task automatic chk(input logic x);
        check_count++;
        if (alert_n !== x) begin
            n_mismatch++;
            $display("ERROR alert_n expected %b seen %b", x, alert_n);
        end
    endtask
    // first read sees a live cause, so the flag must survive it
    task automatic seq(input logic [7:0] p, input logic [7:0] s);
        if (s != 0) begin
            rd(8'h42, s);
            calm();
            rd(8'h42, s);
            rd(8'h42, 8'h00);
            rd(8'h41, 8'h80);
        end else begin
            rd(8'h41, p);
            calm();
            rd(8'h41, p);
        end
        rd(8'h41, 8'h00);
        rd(8'h42, 8'h00);
    endtask
    always @(negedge clk) if (rv === 1'b1) begin
        e = q.pop_front();
        check_count++;
        if (rdata !== e) begin
            n_mismatch++;
            $display("ERROR reg_rdata_r expected %h seen %h", e, rdata);
        end
    end
    initial begin
        #300000;
        n_mismatch++;
        results();
    end
    initial begin
        void'($urandom(32'hc338d7a9));
        calm();
        repeat (20) @(posedge clk);
        #1 resetn = 1;
        chk(1'b1);
        foreach (ra[k]) rd(ra[k], 8'h00);
        m = 8'($urandom);
        wr(8'h74, m);
        rd(8'h74, m);
        wr(8'h75, ~m);
        rd(8'h75, ~m);
        wr(8'h74, 8'h00);
        wr(8'h75, 8'h00);
        for (int i = 0; i < 8; i++) begin
            v[i] = hi[i];
            rd(8'h41, 8'h00);
            v[i] = hi[i] + 8'h01;
            seq(i < 7 ? 8'h40 >> i : 8'h00, i < 7 ? 8'h00 : 8'h01);
            v[i] = lo[i];
            seq(i < 7 ? 8'h40 >> i : 8'h00, i < 7 ? 8'h00 : 8'h01);
        end
        for (int j = 1; j < 8; j++) begin
            c[j] = 1'b1;
            seq(8'h00, 8'h01 << j);
        end
        tps = 1;
        c[5] = 1'b1;
        rd(8'h42, 8'h00);
        tl = 1;
        seq(8'h00, 8'h20);
        tps = 0;
        ccs = 1;
        repeat (2) @(posedge clk);
        #1 code = code ^ 6'($urandom_range(63, 1));
        rd(8'h42, 8'h01);
        rd(8'h42, 8'h00);
        rd(8'h41, 8'h80);
        rd(8'h41, 8'h00);
        ccs = 0;
        c[7] = 1'b1;
        wr(8'h78, 8'h00);
        chk(1'b1);
        wr(8'h78, 8'h01);
        chk(1'b0);
        wr(8'h74, 8'h80);
        chk(1'b1);
        wr(8'h74, 8'h00);
        wr(8'h75, 8'h80);
        chk(1'b1);
        wr(8'h75, 8'h00);
        calm();
        chk(1'b0);
        rd(8'h42, 8'h80);
        chk(1'b1);
        rd(8'h41, 8'h80);
        wr(8'h75, 8'hff);
        c[2] = 1'b1;
        chk(1'b1);
        seq(8'h00, 8'h04);
        repeat (3) @(posedge clk);
        results();
    end
endmodule // tb
`default_nettype wire
